//--- bmc_top.sv
// Our own choices: register access over AXI4-Lite and the register offsets.
`include "bmc_consts.svh"

module bmc_top import bmc_pkg::*; #(
  parameter int unsigned PERIOD_CYCLES =
    `BMC_MEAS_PERIOD_MS * `BMC_NS_PER_MS / `BMC_CLK_PERIOD_NS,
  parameter int unsigned SEC_CYCLES =
    `BMC_MS_PER_S * `BMC_NS_PER_MS / `BMC_CLK_PERIOD_NS
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // AXI4-Lite register slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter control and results.
  output logic conv_start,
  output bmc_chan_t conv_chan,
  output logic conv_res_11bit,
  output logic sense_short,
  input wire logic adc_valid,
  input wire logic signed [15:0] adc_data,
  // Corrected results toward the capacity algorithm.
  output logic signed [15:0] current_ma,
  output logic current_zero,
  output logic signed [15:0] voltage_mv,
  output logic signed [15:0] temperature,
  output logic eoc_temp_valid,
  output logic signed [47:0] charge_acc,
  output logic result_strobe
);

  logic [15:0] cfg_reg [`BMC_CFG_COUNT];
  logic [15:0] cfg_next [`BMC_CFG_COUNT];
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  bmc_state_t st_reg, st_next;
  logic [31:0] per_cnt_reg, per_cnt_next, sec_cnt_reg, sec_cnt_next;
  logic [4:0] az_sec_reg, az_sec_next;
  logic az_due_reg, az_due_next;
  logic [7:0] div_cnt_reg, div_cnt_next;
  logic conv_start_reg, conv_start_next, res11_reg, res11_next, short_reg, short_next;
  bmc_chan_t chan_reg, chan_next;
  logic temp_ext_reg, temp_ext_next;
  logic signed [15:0] raw_cur_reg, raw_cur_next, raw_volt_reg, raw_volt_next;
  logic signed [15:0] raw_temp_reg, raw_temp_next, az_ofs_reg, az_ofs_next;
  logic signed [15:0] cur_reg, cur_next, volt_reg, volt_next, temp_reg, temp_next;
  logic cur_zero_reg, cur_zero_next, eoc_reg, eoc_next, strobe_reg, strobe_next;
  logic signed [47:0] charge_reg, charge_next;
  logic per_tick, sec_tick, measure_now;
  logic [7:0] divider;
  logic signed [15:0] cur_corr, volt_corr, temp_corr, temp_src;
  logic signed [16:0] cur_mag;
  logic signed [16:0] cur_ofs_sum;
  logic signed [33:0] path_prod;
  logic signed [34:0] volt_sum;

  // Reset value of each configuration word.
  function automatic logic [15:0] cfg_rst(input int idx);
    case (idx)
      0: cfg_rst = `BMC_RST_CTRL;
      2: cfg_rst = `BMC_RST_CURR_GAIN;
      6: cfg_rst = `BMC_RST_VOLT_GAIN;
      9, 11: cfg_rst = `BMC_RST_TEMP_GAIN;
      default: cfg_rst = `BMC_RST_ZERO;
    endcase
  endfunction

  // Thermistor voltage to temperature in tenths of a degree, indexed by the top result bits.
  function automatic logic signed [15:0] ntc_lut(input logic [3:0] idx);
    case (idx)
      4'h0: ntc_lut = 16'hFE70;
      4'h1: ntc_lut = 16'hFF38;
      4'h2: ntc_lut = 16'hFFB5;
      4'h3: ntc_lut = 16'h0014;
      4'h4: ntc_lut = 16'h0064;
      4'h5: ntc_lut = 16'h00AA;
      4'h6: ntc_lut = 16'h00E6;
      4'h7: ntc_lut = 16'h0122;
      4'h8: ntc_lut = 16'h015E;
      4'h9: ntc_lut = 16'h019A;
      4'hA: ntc_lut = 16'h01D6;
      4'hB: ntc_lut = 16'h021C;
      4'hC: ntc_lut = 16'h026C;
      4'hD: ntc_lut = 16'h02D0;
      4'hE: ntc_lut = 16'h0352;
      default: ntc_lut = 16'h03E8;
    endcase
  endfunction

  // Correction arithmetic shared by the three quantities.
  assign cur_ofs_sum = 17'(signed'(cfg_reg[1])) + 17'(signed'(cfg_reg[3]));
  assign temp_src = temp_ext_reg ? ntc_lut(raw_temp_reg[10:7]) : raw_temp_reg;

  bmc_corr #(.SHIFT(`BMC_CURR_SHIFT)) u_curr_corr (
    .raw(raw_cur_reg),
    .ofs(cur_ofs_sum),
    .gain(cfg_reg[2]),
    .result(cur_corr)
  );

  bmc_corr #(.SHIFT(`BMC_VOLT_SHIFT)) u_volt_corr (
    .raw(raw_volt_reg),
    .ofs(17'(signed'(cfg_reg[5]))),
    .gain(cfg_reg[6]),
    .result(volt_corr)
  );

  bmc_corr #(.SHIFT(`BMC_TEMP_SHIFT)) u_temp_corr (
    .raw(temp_src),
    .ofs(temp_ext_reg ? 17'(signed'(cfg_reg[10])) : 17'(signed'(cfg_reg[8]))),
    .gain(temp_ext_reg ? cfg_reg[11] : cfg_reg[9]),
    .result(temp_corr)
  );

  // Bus slave: address and data are taken in either order; one write and one read at a time.
  always_comb begin
    cfg_next = cfg_reg;
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    awready_next = awready_reg;
    wready_next = wready_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr;
      awready_next = 1'b0;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
      wready_next = 1'b0;
    end
    if (aw_held_reg && w_held_reg && !bvalid_reg) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `BMC_RESP_SLVERR;
      for (int i = 0; i < `BMC_CFG_COUNT; i++) begin
        if (awaddr_reg == 8'(i * 4)) begin
          bresp_next = `BMC_RESP_OKAY;
          if (wstrb_reg[0]) cfg_next[i][7:0] = wdata_reg[7:0];
          if (wstrb_reg[1]) cfg_next[i][15:8] = wdata_reg[15:8];
        end
      end
      if (awaddr_reg >= `BMC_ADDR_CURRENT && awaddr_reg <= `BMC_ADDR_STATUS &&
          awaddr_reg[1:0] == 2'h0) begin
        bresp_next = `BMC_RESP_OKAY; // Writes to result words are ignored.
      end
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
      awready_next = 1'b1;
      wready_next = 1'b1;
    end
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = `BMC_RESP_OKAY;
      if (s_axi_araddr < `BMC_ADDR_CURRENT && s_axi_araddr[1:0] == 2'h0) begin
        rdata_next = {16'h0000, cfg_reg[s_axi_araddr[5:2]]};
      end else if (s_axi_araddr == `BMC_ADDR_CURRENT) begin
        rdata_next = {15'h0000, cur_zero_reg, cur_reg};
      end else if (s_axi_araddr == `BMC_ADDR_VOLTAGE) begin
        rdata_next = {16'h0000, volt_reg};
      end else if (s_axi_araddr == `BMC_ADDR_TEMP) begin
        rdata_next = {15'h0000, eoc_reg, temp_reg};
      end else if (s_axi_araddr == `BMC_ADDR_CHARGE) begin
        rdata_next = charge_reg[31:0];
      end else if (s_axi_araddr == `BMC_ADDR_STATUS) begin
        rdata_next = {13'h0000, az_due_reg, short_reg, st_reg != BMC_ST_IDLE, az_ofs_reg};
      end else begin
        rdata_next = 32'h00000000;
        rresp_next = `BMC_RESP_SLVERR;
      end
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
  end

  // Period and second time bases, auto-zero scheduling and the measurement sequencer.
  always_comb begin
    per_tick = per_cnt_reg == 32'(PERIOD_CYCLES - 1);
    sec_tick = sec_cnt_reg == 32'(SEC_CYCLES - 1);
    divider = cfg_reg[0][`BMC_CTRL_DIV_MSB:`BMC_CTRL_DIV_LSB];
    if (divider < `BMC_DIV_MIN) divider = `BMC_DIV_MIN;
    measure_now = !cfg_reg[0][`BMC_CTRL_SAMPLE] || div_cnt_reg >= divider - 8'h01;
    per_cnt_next = per_tick ? 32'h00000000 : per_cnt_reg + 32'h00000001;
    sec_cnt_next = sec_tick ? 32'h00000000 : sec_cnt_reg + 32'h00000001;
    az_sec_next = az_sec_reg;
    az_due_next = az_due_reg;
    div_cnt_next = div_cnt_reg;
    st_next = st_reg;
    conv_start_next = 1'b0;
    chan_next = chan_reg;
    res11_next = res11_reg;
    short_next = short_reg;
    temp_ext_next = temp_ext_reg;
    raw_cur_next = raw_cur_reg;
    raw_volt_next = raw_volt_reg;
    raw_temp_next = raw_temp_reg;
    az_ofs_next = az_ofs_reg;
    case (st_reg)
      BMC_ST_IDLE: begin
        if (per_tick) begin
          div_cnt_next = measure_now ? 8'h00 : div_cnt_reg + 8'h01;
          if (measure_now) begin
            st_next = BMC_ST_CURR;
            conv_start_next = 1'b1;
            res11_next = 1'b0;
            if (cfg_reg[0][`BMC_CTRL_AZ_EN] && az_due_reg) begin
              chan_next = BMC_CH_AUTOZERO;
              short_next = 1'b1;
              az_due_next = 1'b0;
            end else begin
              chan_next = BMC_CH_CURRENT;
            end
          end
        end
      end
      BMC_ST_CURR: begin
        if (adc_valid) begin
          if (chan_reg == BMC_CH_AUTOZERO) begin
            az_ofs_next = adc_data;
            short_next = 1'b0;
          end else if (adc_data > signed'(`BMC_CUR_FS_POS)) begin
            raw_cur_next = `BMC_CUR_FS_POS;
          end else if (adc_data < signed'(`BMC_CUR_FS_NEG)) begin
            raw_cur_next = `BMC_CUR_FS_NEG;
          end else begin
            raw_cur_next = adc_data;
          end
          st_next = BMC_ST_VOLT;
          conv_start_next = 1'b1;
          chan_next = BMC_CH_VOLTAGE;
          res11_next = 1'b1;
        end
      end
      BMC_ST_VOLT: begin
        if (adc_valid) begin
          raw_volt_next = adc_data;
          st_next = BMC_ST_TEMP;
          conv_start_next = 1'b1;
          temp_ext_next = cfg_reg[0][`BMC_CTRL_EXT_SEL];
          chan_next = cfg_reg[0][`BMC_CTRL_EXT_SEL] ? BMC_CH_TEMP_EXT : BMC_CH_TEMP_INT;
          res11_next = 1'b1;
        end
      end
      BMC_ST_TEMP: begin
        if (adc_valid) begin
          raw_temp_next = adc_data;
          st_next = BMC_ST_UPD;
        end
      end
      default: begin
        st_next = BMC_ST_IDLE;
      end
    endcase
    // A new second that coincides with the auto-zero start still schedules the next one.
    if (sec_tick) begin
      if (az_sec_reg == 5'(`BMC_AZ_INTERVAL_S - 1)) begin
        az_sec_next = 5'h00;
        az_due_next = 1'b1;
      end else begin
        az_sec_next = az_sec_reg + 5'h01;
      end
    end
  end

  // Result update, pack voltage compensation and charge integration.
  always_comb begin
    cur_next = cur_reg;
    cur_zero_next = cur_zero_reg;
    volt_next = volt_reg;
    temp_next = temp_reg;
    eoc_next = eoc_reg && !cfg_reg[0][`BMC_CTRL_LEDS];
    strobe_next = 1'b0;
    charge_next = charge_reg;
    cur_mag = cur_corr < 16'sh0000 ? -17'(cur_corr) : 17'(cur_corr); // Holds 32768 too.
    path_prod = 34'(cur_reg) * $signed({1'b0, cfg_reg[7]});
    volt_sum = 35'(volt_corr) + 35'(path_prod / `BMC_PATH_DIV);
    if (st_reg == BMC_ST_UPD) begin
      strobe_next = 1'b1;
      if (cur_mag < signed'({1'b0, cfg_reg[4][14:0]})) begin
        cur_next = 16'h0000;
        cur_zero_next = 1'b1;
      end else begin
        cur_next = cur_corr;
        cur_zero_next = 1'b0;
      end
      if (volt_sum > 35'(signed'(`BMC_SAT_MAX))) begin
        volt_next = `BMC_SAT_MAX;
      end else if (volt_sum < 35'(signed'(`BMC_SAT_MIN))) begin
        volt_next = `BMC_SAT_MIN;
      end else begin
        volt_next = volt_sum[15:0];
      end
      temp_next = temp_corr;
      eoc_next = !cfg_reg[0][`BMC_CTRL_LEDS];
    end
    if (per_tick && !cur_zero_reg) begin
      charge_next = charge_reg + 48'(cur_reg);
    end
  end

  // State registers.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `BMC_CFG_COUNT; i++) cfg_reg[i] <= cfg_rst(i);
      {aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg} <= 4'h0;
      {awready_reg, wready_reg, arready_reg} <= 3'h7;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bresp_reg <= `BMC_RESP_OKAY;
      rresp_reg <= `BMC_RESP_OKAY;
      rdata_reg <= 32'h00000000;
      st_reg <= BMC_ST_IDLE;
      per_cnt_reg <= 32'h00000000;
      sec_cnt_reg <= 32'h00000000;
      az_sec_reg <= 5'h00;
      az_due_reg <= 1'b0;
      div_cnt_reg <= 8'h00;
      {conv_start_reg, res11_reg, short_reg, temp_ext_reg} <= 4'h0;
      chan_reg <= BMC_CH_CURRENT;
      {raw_cur_reg, raw_volt_reg, raw_temp_reg, az_ofs_reg} <= 64'h0;
      {cur_reg, volt_reg, temp_reg} <= 48'h0;
      {cur_zero_reg, eoc_reg, strobe_reg} <= 3'h0;
      charge_reg <= 48'h000000000000;
    end else begin
      cfg_reg <= cfg_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      st_reg <= st_next;
      per_cnt_reg <= per_cnt_next;
      sec_cnt_reg <= sec_cnt_next;
      az_sec_reg <= az_sec_next;
      az_due_reg <= az_due_next;
      div_cnt_reg <= div_cnt_next;
      conv_start_reg <= conv_start_next;
      chan_reg <= chan_next;
      res11_reg <= res11_next;
      short_reg <= short_next;
      temp_ext_reg <= temp_ext_next;
      raw_cur_reg <= raw_cur_next;
      raw_volt_reg <= raw_volt_next;
      raw_temp_reg <= raw_temp_next;
      az_ofs_reg <= az_ofs_next;
      cur_reg <= cur_next;
      cur_zero_reg <= cur_zero_next;
      volt_reg <= volt_next;
      temp_reg <= temp_next;
      eoc_reg <= eoc_next;
      strobe_reg <= strobe_next;
      charge_reg <= charge_next;
    end
  end

  // Outputs straight from flip-flops.
  assign {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp} =
    {awready_reg, wready_reg, bvalid_reg, bresp_reg};
  assign {s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata} =
    {arready_reg, rvalid_reg, rresp_reg, rdata_reg};
  assign {conv_start, conv_chan, conv_res_11bit, sense_short} =
    {conv_start_reg, chan_reg, res11_reg, short_reg};
  assign {current_ma, current_zero, voltage_mv, temperature} =
    {cur_reg, cur_zero_reg, volt_reg, temp_reg};
  assign {eoc_temp_valid, charge_acc, result_strobe} = {eoc_reg, charge_reg, strobe_reg};

  // Checks on the block's own behaviour.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_cur_zero;
    st_reg == BMC_ST_UPD && cur_mag < signed'({1'b0, cfg_reg[4][14:0]}) |=>
      cur_reg == 16'h0000 && cur_zero_reg;
  endproperty
  a_cur_zero: assert property (p_cur_zero) else $error("Zero-band current not zeroed.");

  property p_cur_corr;
    st_reg == BMC_ST_UPD && !(cur_mag < signed'({1'b0, cfg_reg[4][14:0]})) |=>
      cur_reg == $past(cur_corr) && !cur_zero_reg;
  endproperty
  a_cur_corr: assert property (p_cur_corr) else $error("Current result mismatch.");

  property p_integrate;
    per_tick && !cur_zero_reg |=> charge_reg == $past(charge_reg) + 48'($past(cur_reg));
  endproperty
  a_integrate: assert property (p_integrate) else $error("Charge not integrated.");

  property p_az_interval;
    sec_tick && az_sec_reg == 5'(`BMC_AZ_INTERVAL_S - 1) |=>
      az_due_reg && az_sec_reg == 5'h00;
  endproperty
  a_az_interval: assert property (p_az_interval) else $error("Auto-zero not scheduled.");

  property p_short;
    st_reg == BMC_ST_CURR && chan_reg == BMC_CH_AUTOZERO && !adc_valid |=> short_reg;
  endproperty
  a_short: assert property (p_short) else $error("Sense inputs not shorted.");

  property p_az_keep;
    st_reg == BMC_ST_CURR && chan_reg == BMC_CH_AUTOZERO && adc_valid |=>
      $stable(raw_cur_reg) ##1 $stable(raw_cur_reg);
  endproperty
  a_az_keep: assert property (p_az_keep) else $error("Current sample not kept.");

  property p_res11;
    conv_start_reg && chan_reg != BMC_CH_CURRENT && chan_reg != BMC_CH_AUTOZERO |-> res11_reg;
  endproperty
  a_res11: assert property (p_res11) else $error("Wrong resolution for conversion.");

  property p_volt_order;
    conv_start_reg && chan_reg == BMC_CH_VOLTAGE |-> $past(st_reg) == BMC_ST_CURR;
  endproperty
  a_volt_order: assert property (p_volt_order) else $error("Voltage sampled out of turn.");

  property p_cycle_start;
    conv_start_reg && (chan_reg == BMC_CH_CURRENT || chan_reg == BMC_CH_AUTOZERO) |->
      $past(per_tick) && $past(measure_now);
  endproperty
  a_cycle_start: assert property (p_cycle_start) else $error("Cycle started off tick.");

  property p_leds;
    cfg_reg[0][`BMC_CTRL_LEDS] |=> !eoc_reg;
  endproperty
  a_leds: assert property (p_leds) else $error("Temperature valid while LEDs lit.");

endmodule

//--- bmc_consts.svh
`ifndef BMC_CONSTS_SVH
`define BMC_CONSTS_SVH

// Clock and timing figures.
`define BMC_CLK_PERIOD_NS 5
`define BMC_NS_PER_MS 1000000
`define BMC_MS_PER_S 1000
`define BMC_MEAS_PERIOD_MS 500
`define BMC_AZ_INTERVAL_S 30

// Register byte addresses; configuration words sit at index address / 4.
`define BMC_ADDR_CTRL 8'h00
`define BMC_ADDR_CURR_OFS 8'h04
`define BMC_ADDR_CURR_GAIN 8'h08
`define BMC_ADDR_CHIP_ZERO 8'h0C
`define BMC_ADDR_ZERO_BAND 8'h10
`define BMC_ADDR_VOLT_OFS 8'h14
`define BMC_ADDR_VOLT_GAIN 8'h18
`define BMC_ADDR_PATH_RES 8'h1C
`define BMC_ADDR_TI_OFS 8'h20
`define BMC_ADDR_TI_GAIN 8'h24
`define BMC_ADDR_TE_OFS 8'h28
`define BMC_ADDR_TE_GAIN 8'h2C
`define BMC_ADDR_CURRENT 8'h30
`define BMC_ADDR_VOLTAGE 8'h34
`define BMC_ADDR_TEMP 8'h38
`define BMC_ADDR_CHARGE 8'h3C
`define BMC_ADDR_STATUS 8'h40
`define BMC_CFG_COUNT 12

// Control word fields.
`define BMC_CTRL_AZ_EN 0
`define BMC_CTRL_EXT_SEL 1
`define BMC_CTRL_SAMPLE 2
`define BMC_CTRL_LEDS 3
`define BMC_CTRL_DIV_MSB 15
`define BMC_CTRL_DIV_LSB 8
`define BMC_DIV_MIN 8'h02

// Reset values of the configuration words.
`define BMC_RST_CTRL 16'h0201
`define BMC_RST_CURR_GAIN 16'h4000
`define BMC_RST_VOLT_GAIN 16'h0800
`define BMC_RST_TEMP_GAIN 16'h4000
`define BMC_RST_ZERO 16'h0000

// Correction scaling.
`define BMC_CURR_SHIFT 14
`define BMC_VOLT_SHIFT 11
`define BMC_TEMP_SHIFT 14
`define BMC_PATH_DIV 34'sh0000FFFF
`define BMC_CUR_FS_POS 16'h3FFF
`define BMC_CUR_FS_NEG 16'hC000
`define BMC_SAT_MAX 16'h7FFF
`define BMC_SAT_MIN 16'h8000

// Bus responses.
`define BMC_RESP_OKAY 2'h0
`define BMC_RESP_SLVERR 2'h2

`endif

//--- bmc_pkg.sv
package bmc_pkg;

  // Sequencer states of one measurement period.
  typedef enum logic [2:0] {BMC_ST_IDLE, BMC_ST_CURR, BMC_ST_VOLT, BMC_ST_TEMP, BMC_ST_UPD}
    bmc_state_t;

  // Converter channel selection.
  typedef enum logic [2:0] {BMC_CH_CURRENT, BMC_CH_VOLTAGE, BMC_CH_TEMP_INT, BMC_CH_TEMP_EXT,
    BMC_CH_AUTOZERO} bmc_chan_t;

endpackage

//--- bmc_corr.sv
`include "bmc_consts.svh"

module bmc_corr import bmc_pkg::*; #(
  parameter int unsigned SHIFT = 14
) (
  // Raw result and calibration constants.
  input wire logic signed [15:0] raw,
  input wire logic signed [16:0] ofs,
  input wire logic [15:0] gain,
  // Corrected, saturated result.
  output logic signed [15:0] result
);

  localparam logic signed [34:0] DIVISOR = 35'sh1 <<< SHIFT;

  logic signed [17:0] diff;
  logic signed [34:0] prod;
  logic signed [34:0] quot;

  // Offset removal, gain, division that truncates toward zero, then saturation.
  always_comb begin
    diff = 18'(raw) - 18'(ofs);
    prod = 35'(diff) * $signed({1'b0, gain});
    quot = prod / DIVISOR;
    if (quot > 35'(signed'(`BMC_SAT_MAX))) begin
      result = `BMC_SAT_MAX;
    end else if (quot < 35'(signed'(`BMC_SAT_MIN))) begin
      result = `BMC_SAT_MIN;
    end else begin
      result = quot[15:0];
    end
  end

endmodule

//--- bmc_adc_model.sv
module bmc_adc_model import bmc_pkg::*; #(
  parameter int DLY = 3
) (
  // Clock, reset and request.
  input wire logic core_clk,
  input wire logic reset,
  input wire logic conv_start,
  input wire bmc_chan_t conv_chan,
  input wire logic sense_short,
  // Result.
  output logic adc_valid,
  output logic signed [15:0] adc_data
);
  logic [3:0] cnt;
  bmc_chan_t ch;
  // Answer each start after DLY cycles; between results the bus toggles.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt <= 4'h0;
      ch <= BMC_CH_CURRENT;
      adc_valid <= 1'b0;
      adc_data <= 16'sh0000;
    end else begin
      adc_valid <= (cnt == 4'h1);
      if (conv_start) begin
        cnt <= 4'(DLY);
        ch <= conv_chan;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
      if (cnt == 4'h1) begin
        case (ch)
          BMC_CH_CURRENT: adc_data <= 16'sh0400;
          BMC_CH_VOLTAGE: adc_data <= 16'sh0600;
          BMC_CH_AUTOZERO: adc_data <= sense_short ? 16'sh0005 : 16'sh7FFF;
          default: adc_data <= 16'sh0123;
        endcase
      end else begin
        adc_data <= ~adc_data;
      end
    end
  end
endmodule

//--- tb.sv
module tb;
  import bmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv;
  logic cs, r11, ss, av, cz, eoc, stb;
  logic [7:0] aw, ar;
  logic [31:0] wd, rd;
  logic [1:0] br, rr;
  logic signed [15:0] ad, cur, vol, tmp;
  logic signed [47:0] chg, c0;
  bmc_chan_t ch;
  int n_errors = 0;
  int check_count = 0;
  bmc_top #(.PERIOD_CYCLES(40), .SEC_CYCLES(20)) bmc_top_i (.core_clk(core_clk),
    .reset(reset), .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ar),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .conv_start(cs), .conv_chan(ch),
    .conv_res_11bit(r11), .sense_short(ss), .adc_valid(av), .adc_data(ad),
    .current_ma(cur), .current_zero(cz), .voltage_mv(vol), .temperature(tmp),
    .eoc_temp_valid(eoc), .charge_acc(chg), .result_strobe(stb));
  bmc_adc_model bmc_adc_model_i (.core_clk(core_clk), .reset(reset), .conv_start(cs),
    .conv_chan(ch), .sense_short(ss), .adc_valid(av), .adc_data(ad));
  task automatic final_report;
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Write one word; address and data are released as each is taken.
  task automatic wrw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge core_clk);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    bre <= 1'b0;
    chk(br, e);
  endtask
  task automatic rdw(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
    @(posedge core_clk);
    ar <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rre <= 1'b0;
    chk(rr, er);
    chk(rd & m, e);
  endtask
  task automatic wstb(input int n);
    repeat (n) do @(posedge core_clk); while (stb !== 1'b1);
    #1;
  endtask
  task automatic wstart;
    do @(posedge core_clk); while (cs !== 1'b1);
    #1;
  endtask
  task automatic t_regs;
    rdw(8'h00, 32'hFFFFFFFF, 32'h00000201, 2'h0);
    rdw(8'h08, 32'hFFFFFFFF, 32'h00004000, 2'h0);
    rdw(8'h44, 32'hFFFFFFFF, 32'h00000000, 2'h2);
    wrw(8'h30, 32'h00001234, 2'h0);
  endtask
  task automatic t_corr;
    wrw(8'h04, 32'h00000010, 2'h0);
    wrw(8'h0C, 32'h00000008, 2'h0);
    wrw(8'h08, 32'h00002000, 2'h0);
    wrw(8'h1C, 32'h0000FFFF, 2'h0);
    wstb(3);
    chk(cur, 16'sd500);
    chk(cz, 1'b0);
    chk(vol, 16'sd2036);
    chk(tmp, 16'sh0123);
    chk(eoc, 1'b1);
    c0 = chg;
    wstb(1);
    chk(chg, c0 + 48'sh0000000001F4);
  endtask
  task automatic t_az;
    do wstart(); while (ch !== BMC_CH_AUTOZERO);
    chk(ss, 1'b1);
    wstart();
    chk(ch, BMC_CH_VOLTAGE);
    chk(r11, 1'b1);
    chk(ss, 1'b0);
    wstb(1);
    chk(cur, 16'sd500);
    rdw(8'h40, 32'h0000FFFF, 32'h00000005, 2'h0);
  endtask
  task automatic t_band;
    wrw(8'h10, 32'h00000258, 2'h0);
    wstb(2);
    chk(cur, 16'sd0);
    chk(cz, 1'b1);
    c0 = chg;
    wstb(1);
    chk(chg, c0);
    wrw(8'h00, 32'h00000209, 2'h0);
    wstb(1);
    chk(eoc, 1'b0);
  endtask
  // Voltage and internal temperature constants, then sample mode with the thermistor.
  task automatic t_mode;
    int n;
    wrw(8'h10, 32'h00000000, 2'h0);
    wrw(8'h14, 32'h00000036, 2'h0);
    wrw(8'h18, 32'h00001000, 2'h0);
    wrw(8'h20, 32'h00000023, 2'h0);
    wrw(8'h24, 32'h00008000, 2'h0);
    wrw(8'h2C, 32'h00000000, 2'h0);
    wstb(2);
    chk(vol, 16'sh0D88);
    chk(tmp, 16'sh0200);
    wrw(8'h18, 32'h0000FFFF, 2'h0);
    wrw(8'h00, 32'h00000406, 2'h0);
    wstb(2);
    c0 = chg;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (stb !== 1'b1);
    #1;
    chk(n, 32'h000000A0);
    chk(chg, c0 + 48'sh0000000007D0);
    chk(ch, BMC_CH_TEMP_EXT);
    chk(tmp, 16'sh0000);
    chk(vol, 16'sh7FFF);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    {reset, awv, wv, bre, arv, rre, aw, ar, wd} = {1'b1, 5'h00, 8'h00, 8'h00, 32'h0};
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    t_regs();
    t_corr();
    t_az();
    t_band();
    t_mode();
    final_report();
  end
  initial begin
    repeat (4000) @(posedge core_clk);
    n_errors++;
    $display("mismatch %0t watchdog expired", $time);
    final_report();
  end
endmodule
